// ==== design/pac_defs.svh ====
// constants for the pipelined converter control block: offsets, fields, resets, counts
`ifndef PAC_DEFS_SVH
`define PAC_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the apb slave
// ----------------------------------------------------------------------------
`define PAC_OFS_CTRL      12'h000   // control: software calibrate, software power-down
`define PAC_OFS_STATUS    12'h004   // status of the sequencer
`define PAC_OFS_SAMPLE    12'h008   // last output sample
`define PAC_OFS_COEF_SEL  12'h00C   // coefficient index for readback
`define PAC_OFS_COEF_DATA 12'h010   // coefficient value at the selected index

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PAC_CTRL_CAL      0         // write 1: request calibration
`define PAC_CTRL_PD       1         // software power-down, ored with the pin
`define PAC_ST_READY      0
`define PAC_ST_CAL        1
`define PAC_ST_PD         2
`define PAC_ST_WAKE       3
`define PAC_ST_FILLED     4
`define PAC_ST_PEND       5
`define PAC_SMP_OVR       12        // over-range bit above the 12-bit code

// ----------------------------------------------------------------------------
// reset values and timing counts, in conversion clock cycles
// ----------------------------------------------------------------------------
`define PAC_CTRL_RST      2'h0
`define PAC_CAL_REQ_MIN   2'h3      // least request width
`define PAC_CAL_CYCLES    12'hFA0   // 4000 cycles of calibration
`define PAC_WAKE_CYCLES   12'hFA0   // 4000 cycles of wake interval
`define PAC_PIPE_LAT      4'hA      // 10 cycles conversion latency
`define PAC_STAGES        15        // number of one-bit pipeline stages
`define PAC_SLICE_BITS    8         // 256 cycles of averaging per stage
`define PAC_FRAC_BITS     4         // coefficient fraction bits

`endif

// ==== design/pac_pkg.sv ====
// types shared by the converter control block
`default_nettype none

package pac_pkg;
   // sequencer states
   typedef enum logic [1:0] {ST_CAL, ST_RUN, ST_PD, ST_WAKE} pac_state_type;

   // coefficient store: one 16-bit weight per raw stage bit, 1/16 lsb units
   typedef logic [14:0][15:0] pac_coef_type;

   // one corrected output sample
   typedef struct packed {
      logic        over_range;
      logic [11:0] code;
   } pac_sample_type;
endpackage

`default_nettype wire

// ==== design/pac_corrector.sv ====
// correction stage: weights the raw stage decisions into a 12-bit straight binary code
`default_nettype none
`include "pac_defs.svh"

module pac_corrector (
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   input  wire logic [14:0]     raw_bits_i,
   input  wire logic            over_range_i,
   input  wire pac_pkg::pac_coef_type coef_i,
   output pac_pkg::pac_sample_type sample_o
);
   import pac_pkg::*;

   // ----------------------------------------------------------------------------
   // weighted sum, bit 14 is the first (most significant) stage
   // ----------------------------------------------------------------------------
   logic [19:0] sum;   // 15 x 16-bit terms fit in 20 bits
   logic [15:0] whole; // sum without fraction

   always_comb begin
      sum = 20'h00000;
      for (int k = 0; k < `PAC_STAGES; k++) begin
         if (raw_bits_i[k]) begin
            sum = sum + {4'h0, coef_i[k]};
         end
      end
      whole = sum[19:`PAC_FRAC_BITS];
   end

   // ----------------------------------------------------------------------------
   // saturate to 12 bits; miscalibrated weights must not wrap the code
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_o <= '0;
      end else begin
         sample_o.code       <= (whole > 16'h0FFF) ? 12'hFFF : whole[11:0];
         sample_o.over_range <= over_range_i;
      end
   end
endmodule

`default_nettype wire

// ==== design/pac_adc_ctrl.sv ====
// top of the converter control block: sequencer, calibration, output drive and apb slave
//
// Functional notes
// - calibration lasts 4000 clock cycles
// - samples during calibration are meaningless
// - output enable low drives data outputs
// - output enable high floats data outputs
// - power-down held high stops conversion
// - conversion resumes after wake interval
// - pipeline refills before outputs are valid (ready_o does not wait for it; only the status filled bit does)
// - coefficients survive power-down
// - calibrate at power-on and on request
// - one new sample every clock
// - fifteen weighted stage bits form code
// - calibration writes one coefficient per bit
// - power-down exit takes 4000 cycles
// - ready low in calibration and power-down
// - over-range high outside reference span
// - output is 12-bit straight binary
`default_nettype none
`include "pac_defs.svh"

module pac_adc_ctrl (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // host controls
   input  wire logic                 cal_req_i,
   input  wire logic                 out_en_n_i,
   input  wire logic                 power_down_request_i,
   // analog core side
   input  wire logic [14:0]          raw_bits_i,
   input  wire logic                 over_range_i,
   input  wire logic [15:0]          cal_meas_i,
   output logic                      core_cal_mode_o,
   output logic [3:0]                cal_stage_o,
   output logic                      core_power_down_o,
   // output pins
   output pac_pkg::pac_sample_type   sample_o,
   output logic                      data_oe_o,
   output logic                      ready_o,
   // apb slave
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [11:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic [31:0]               prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o
);
   import pac_pkg::*;

   // ----------------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------------
   // nominal binary weight of stage k in 1/16 lsb: all ones sums to 4095
   function automatic logic [15:0] nominal_weight(input int k);
      nominal_weight = 16'h0001 << (k + 1);
   endfunction

   // true for a mapped register offset
   function automatic logic addr_ok(input logic [11:0] a);
      addr_ok = (a == `PAC_OFS_CTRL) || (a == `PAC_OFS_STATUS) || (a == `PAC_OFS_SAMPLE) ||
                (a == `PAC_OFS_COEF_SEL) || (a == `PAC_OFS_COEF_DATA);
   endfunction

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   pac_state_type  st_q;          // sequencer state
   logic [11:0]    cnt_q;         // cycles spent in calibration or wake
   logic [1:0]     req_cnt_q;     // consecutive high cycles of the request pin
   logic           cal_pend_q;    // request waiting for the sequencer
   logic [1:0]     ctrl_q;        // software control bits
   logic [3:0]     coef_sel_q;    // readback index
   logic [3:0]     fill_q;        // cycles since conversion resumed
   logic [23:0]    acc_q;         // averaging accumulator for one stage
   pac_coef_type   coef_q;        // coefficient memory
   pac_sample_type corr;          // corrected sample from the correction stage
   logic           pd_any;        // pin or software power-down
   logic           req_fire;      // qualified calibrate request this cycle
   logic           sw_cal;        // software calibrate write this cycle
   logic           apb_acc;       // apb access completing this cycle
   logic           filled;        // pipeline refilled
   logic [11:0]    cnt_inc;       // count one step ahead, drives the stage index

   assign pd_any   = power_down_request_i | ctrl_q[`PAC_CTRL_PD];
   assign apb_acc  = psel_i & penable_i & pready_o;
   assign sw_cal   = apb_acc & pwrite_i & (paddr_i == `PAC_OFS_CTRL) &
                     pwdata_i[`PAC_CTRL_CAL];
   // third consecutive high cycle qualifies the request; shorter pulses are dropped
   assign req_fire = cal_req_i & (req_cnt_q == (`PAC_CAL_REQ_MIN - 2'h1));
   assign filled   = (fill_q == `PAC_PIPE_LAT);
   assign cnt_inc  = cnt_q + 12'h001;

   // ----------------------------------------------------------------------------
   // request width counter
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_cnt_q <= 2'h0;
      end else if (!cal_req_i) begin
         req_cnt_q <= 2'h0;
      end else if (req_cnt_q != `PAC_CAL_REQ_MIN) begin
         req_cnt_q <= req_cnt_q + 2'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // pending calibration: a new request wins over the clear at cal start
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cal_pend_q <= 1'b0;
      end else if ((req_fire || sw_cal) && st_q != ST_CAL) begin
         cal_pend_q <= 1'b1;
      end else if (st_q == ST_RUN && !pd_any) begin
         cal_pend_q <= 1'b0;                                      // taken by the sequencer
      end
   end

   // ----------------------------------------------------------------------------
   // sequencer; reset stands in for power-on and starts a calibration
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q  <= ST_CAL;
         cnt_q <= 12'h000;
      end else begin
         case (st_q)
            ST_CAL: begin
               // power-down aborts calibration; the pending flag is not needed then
               if (pd_any) begin
                  st_q  <= ST_PD;
                  cnt_q <= 12'h000;
               end else if (cnt_q == `PAC_CAL_CYCLES - 12'h001) begin
                  st_q  <= ST_RUN;
                  cnt_q <= 12'h000;
               end else begin
                  cnt_q <= cnt_q + 12'h001;
               end
            end
            ST_RUN: begin
               if (pd_any) begin
                  st_q <= ST_PD;
               end else if (cal_pend_q) begin
                  st_q  <= ST_CAL;
                  cnt_q <= 12'h000;
               end
            end
            ST_PD: begin
               cnt_q <= 12'h000;
               if (!pd_any) begin
                  st_q <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (pd_any) begin
                  st_q  <= ST_PD;
                  cnt_q <= 12'h000;
               end else if (cnt_q == `PAC_WAKE_CYCLES - 12'h001) begin
                  st_q  <= ST_RUN;
                  cnt_q <= 12'h000;
               end else begin
                  cnt_q <= cnt_q + 12'h001;
               end
            end
            default: begin
               st_q  <= ST_CAL;
               cnt_q <= 12'h000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // calibration: each stage gets 256 averaged measurements, rest of 4000 idles
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= 24'h000000;
         for (int k = 0; k < `PAC_STAGES; k++) begin
            coef_q[k] <= nominal_weight(k);
         end
      end else if (st_q == ST_CAL && cnt_q[11:`PAC_SLICE_BITS] < 4'hF) begin
         if (cnt_q[7:0] == 8'hFF) begin
            // one coefficient per raw bit; power-down never touches this store
            coef_q[cnt_q[11:8]] <= 16'((acc_q + {8'h00, cal_meas_i}) >> `PAC_SLICE_BITS);
            acc_q               <= 24'h000000;
         end else begin
            acc_q <= acc_q + {8'h00, cal_meas_i};
         end
      end else begin
         acc_q <= 24'h000000;
      end
   end

   // ----------------------------------------------------------------------------
   // correction stage
   // ----------------------------------------------------------------------------
   pac_corrector u_corr (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .raw_bits_i   (raw_bits_i),
      .over_range_i (over_range_i),
      .coef_i       (coef_q),
      .sample_o     (corr)
   );

   // ----------------------------------------------------------------------------
   // pipeline refill counter: contents were lost while powered down or calibrating
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || st_q != ST_RUN) begin
         fill_q <= 4'h0;
      end else if (!filled) begin
         fill_q <= fill_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // output pins, all registered
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_o          <= '0;
         data_oe_o         <= 1'b0;
         ready_o           <= 1'b0;
         core_cal_mode_o   <= 1'b0;
         core_power_down_o <= 1'b0;
         cal_stage_o       <= 4'h0;
      end else begin
         sample_o          <= corr;
         data_oe_o         <= !out_en_n_i;
         // ready low marks calibration samples as junk for the host
         ready_o           <= (st_q == ST_RUN) && !pd_any && !cal_pend_q;
         core_cal_mode_o   <= (st_q == ST_CAL) && !pd_any;
         core_power_down_o <= (st_q == ST_PD) || pd_any;
         // index leads the count by one cycle: the measurement taken at an edge
         // then belongs to the stage being averaged, not to the one before it
         cal_stage_o       <= cnt_inc[11:8];
      end
   end

   // ----------------------------------------------------------------------------
   // apb slave: one wait state, pready high on the second access cycle
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= psel_i & penable_i & !pready_o;
         pslverr_o <= psel_i & penable_i & !pready_o & !addr_ok(paddr_i);
         prdata_o  <= 32'h00000000;
         if (psel_i && penable_i && !pready_o && !pwrite_i) begin
            case (paddr_i)
               `PAC_OFS_CTRL:      prdata_o <= {30'h0, ctrl_q[1], 1'b0};
               `PAC_OFS_STATUS:    prdata_o <= {26'h0, cal_pend_q, filled, st_q == ST_WAKE,
                                                st_q == ST_PD, st_q == ST_CAL, ready_o};
               `PAC_OFS_SAMPLE:    prdata_o <= {19'h0, sample_o};
               `PAC_OFS_COEF_SEL:  prdata_o <= {28'h0, coef_sel_q};
               `PAC_OFS_COEF_DATA: prdata_o <= (coef_sel_q < 4'hF) ?
                                               {16'h0, coef_q[coef_sel_q]} : 32'h00000000;
               default:            prdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // software control registers; the calibrate bit is a strobe and reads zero
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q     <= `PAC_CTRL_RST;
         coef_sel_q <= 4'h0;
      end else if (apb_acc && pwrite_i) begin
         if (paddr_i == `PAC_OFS_CTRL) begin
            ctrl_q[`PAC_CTRL_PD] <= pwdata_i[`PAC_CTRL_PD];
         end
         if (paddr_i == `PAC_OFS_COEF_SEL) begin
            coef_sel_q <= pwdata_i[3:0];
         end
      end
   end

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_req_held;
      cal_req_i [*3];
   endsequence

   sequence s_cal_end;
      (st_q == ST_CAL) && !pd_any && (cnt_q == `PAC_CAL_CYCLES - 12'h001);
   endsequence

   a_cal_bound: assert property ((st_q == ST_CAL) |-> (cnt_q < 12'hFA0))
      else $error("calibration ran past 4000 cycles");
   a_cal_finish: assert property (s_cal_end |=> (st_q == ST_RUN) ##1 (fill_q == 4'h1))
      else $error("calibration did not end at cycle 4000");
   a_wake_finish: assert property (((st_q == ST_WAKE) && !pd_any &&
                                    (cnt_q == `PAC_WAKE_CYCLES - 12'h001)) |=> st_q == ST_RUN)
      else $error("wake interval length wrong");
   a_pd_enter: assert property (power_down_request_i |=> (st_q == ST_PD) && !ready_o)
      else $error("power-down not entered");
   a_ready_low: assert property ((st_q != ST_RUN) |=> !ready_o)
      else $error("ready high outside conversion");
   a_oe_drive: assert property (!out_en_n_i |=> data_oe_o)
      else $error("outputs not driven");
   a_oe_float: assert property (out_en_n_i |=> !data_oe_o)
      else $error("outputs not floated");
   a_req_taken: assert property (s_req_held |=> (cal_pend_q || st_q == ST_CAL))
      else $error("held calibrate request lost");
   a_coef_keep: assert property ((st_q == ST_PD) |=> $stable(coef_q))
      else $error("coefficients changed in power-down");
   a_fill_wait: assert property (((st_q == ST_RUN) && $past(st_q) != ST_RUN) |->
                                 !filled [*8])
      else $error("pipeline counted valid too early");
endmodule

`default_nettype wire

// ==== testbench/pac_core_model.sv ====
// analog core stand-in: answers calibration measurements for the stage under test
`default_nettype none

module pac_core_model (
   input  wire logic        cal_mode_i,
   input  wire logic [3:0]  stage_i,
   output logic      [15:0] meas_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // measurement path
   // ---------------------------------------------------------------
   // nominal weight of the stage in 1/16 lsb, answered in the same cycle;
   // outside calibration the line rests at zero, so a sample taken before
   // the core entered calibration only pulls a weight down, never up
   assign meas_o = cal_mode_i ? 16'(32'h2 << stage_i) : 16'h0000;
endmodule

`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench for the converter control block
`default_nettype none
`include "pac_defs.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pac_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic           clk_i = 1'b0;
   logic           rst_i = 1'b1;
   logic           cal_req = 1'b0;
   logic           oen = 1'b1;                       // active low enable
   logic           pd = 1'b0;
   logic [14:0]    raw = 15'h0000;
   logic           ovr = 1'b0;
   logic [15:0]    meas;
   logic           core_cal, core_pd, data_oe, ready, pready, pslverr;
   logic [3:0]     stage;
   pac_sample_type smp;
   logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]    paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0, prdata, rd;
   logic           er;
   logic [15:0]    lf = 16'h37F0;                    // seed 14320
   logic [16:0]    h1 = 17'h0, h2 = 17'h0, h3 = 17'h0; // {oen, ovr, raw} history
   logic           chk_on = 1'b0;
   int             failures = 0, checked = 0, cyc = 0, n;

   pac_adc_ctrl u_pac_adc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cal_req_i(cal_req),
      .out_en_n_i(oen), .power_down_request_i(pd), .raw_bits_i(raw), .over_range_i(ovr),
      .cal_meas_i(meas), .core_cal_mode_o(core_cal), .cal_stage_o(stage),
      .core_power_down_o(core_pd), .sample_o(smp), .data_oe_o(data_oe), .ready_o(ready),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   pac_core_model u_pac_core_model (.cal_mode_i(core_cal),
      .stage_i(stage), .meas_o(meas));

   // model rate only: the logic counts cycles, never time
   initial forever #12.5 clk_i = ~clk_i;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // nominal weights give code = raw / 8
   function automatic logic [31:0] nom(input logic [14:0] r);
      return {20'h0, 12'(r >> 3)};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // range compare: calibration averaging may trim a weight by one step
   task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] g);
      checked++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         failures++;
         $display("Error %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask
   task automatic report_and_stop;
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // apb transfer: request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      // no timeout of its own: if pready never rises, only the bench's hang guard ends this wait
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_rdy(input logic v, input int lim);
      n = 0;
      while (ready !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic cal_pulse(input int k);
      @(posedge clk_i);
      cal_req <= 1'b1;
      repeat (k) @(posedge clk_i);
      cal_req <= 1'b0;
   endtask
   task automatic coef_chk;
      for (int k = 0; k < 15; k++) begin
         apb(1'b1, `PAC_OFS_COEF_SEL, 32'(k));
         apb(1'b0, `PAC_OFS_COEF_DATA, 32'h0);
         chk_rng("coef", (32'h2 << k) - 2, 32'h2 << k, rd);
      end
   endtask
   // ---------------------------------------------------------------
   // random sample stream and its checks
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (chk_on && ready === 1'b1) begin
         chk_rng("code", nom(h3[14:0]), nom(h3[14:0]) + 3,
                 {20'h0, smp.code} + 2);
         chk("over_range", h3[15], smp.over_range);
      end
      if (chk_on) chk("data_oe", !h2[16], data_oe);
      lf = lfsr(lf);
      raw <= lf[14:0];
      ovr <= lf[15] & lf[7];
      oen <= lf[3];
      h1 <= {lf[3], lf[15] & lf[7], lf[14:0]};
      h2 <= h1;
      h3 <= h2;
   end
   // hang guard: the whole run needs about 17000 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         report_and_stop();
      end
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_rdy(1'b1, 4100);
      chk("ready_power_on", 1, ready);
      chk_on <= 1'b1;
      cal_pulse(2);
      repeat (8) @(posedge clk_i);
      chk("ready_short_req", 1, ready);
      cal_pulse(3);
      wait_rdy(1'b0, 10);
      @(posedge clk_i);
      chk("core_cal_mode", 1, core_cal);
      wait_rdy(1'b1, 4100);
      chk("cal_length", 4000, n);
      coef_chk();
      apb(1'b1, `PAC_OFS_CTRL, 32'h1);
      wait_rdy(1'b0, 10);
      @(posedge clk_i);
      chk("sw_core_cal", 1, core_cal);
      wait_rdy(1'b1, 4100);
      chk("sw_cal_length", 4000, n);
      apb(1'b0, `PAC_OFS_CTRL, 32'h0);
      chk("ctrl_read", 0, rd);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped_err", 1, er);
      chk("unmapped_data", 0, rd);
      pd <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk("ready_pd", 0, ready);
      chk("core_pd", 1, core_pd);
      repeat (20) @(posedge clk_i);
      apb(1'b0, `PAC_OFS_STATUS, 32'h0);
      chk("status_pd", 1, rd[`PAC_ST_PD]);
      pd <= 1'b0;
      wait_rdy(1'b1, 4100);
      chk_rng("wake_length", 4000, 4005, n);
      apb(1'b0, `PAC_OFS_STATUS, 32'h0);
      chk("refill_early", 0, rd[`PAC_ST_FILLED]);
      repeat (12) @(posedge clk_i);
      apb(1'b0, `PAC_OFS_STATUS, 32'h0);
      chk("refill_done", 1, rd[`PAC_ST_FILLED]);
      coef_chk();
      repeat (500) @(posedge clk_i);
      report_and_stop();
   end
endmodule

`default_nettype wire
